// >>> rtl/iat_pkg.sv
// Constants, types and register map of the interval and auto-reload timer
package iat_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] IAT_ADDR_MODE = 16'hffb2;
    localparam logic [15:0] IAT_ADDR_COUNT = 16'hffb3;
    localparam logic [15:0] IAT_ADDR_STATUS = 16'hffa0;
    localparam logic [15:0] IAT_ADDR_MASK = 16'hffa1;
    localparam logic [15:0] IAT_ADDR_EDGE = 16'hffa2;

    // ------------------------------------------------------------
    // Reset values and fixed fields
    // ------------------------------------------------------------
    localparam logic [7:0] IAT_MODE_RESET = 8'h78;
    localparam logic [7:0] IAT_COUNT_RESET = 8'h00;
    localparam logic [7:0] IAT_RELOAD_RESET = 8'h00;
    localparam logic [7:0] IAT_COUNT_MAX = 8'hff;
    localparam logic [7:0] IAT_COUNT_WRAP = 8'h00;
    localparam logic [3:0] IAT_MODE_FIXED_ONES = 4'hf;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IAT_MODE_RELOAD_BIT = 7;
    localparam int IAT_STATUS_OVF_BIT = 0;
    localparam int IAT_MASK_OVF_BIT = 0;
    localparam int IAT_EDGE_SEL_BIT = 0;

    // ------------------------------------------------------------
    // Prescaler: tick when the low bits of the divider are all ones
    // ------------------------------------------------------------
    localparam int IAT_PRESC_WIDTH = 13;
    localparam logic [12:0] IAT_MASK_DIV8192 = 13'h1fff;
    localparam logic [12:0] IAT_MASK_DIV2048 = 13'h07ff;
    localparam logic [12:0] IAT_MASK_DIV512 = 13'h01ff;
    localparam logic [12:0] IAT_MASK_DIV256 = 13'h00ff;
    localparam logic [12:0] IAT_MASK_DIV64 = 13'h003f;
    localparam logic [12:0] IAT_MASK_DIV16 = 13'h000f;
    localparam logic [12:0] IAT_MASK_DIV4 = 13'h0003;

    typedef enum logic [2:0] {
        IAT_CLK_DIV8192 = 3'b000,
        IAT_CLK_DIV2048 = 3'b001,
        IAT_CLK_DIV512 = 3'b010,
        IAT_CLK_DIV256 = 3'b011,
        IAT_CLK_DIV64 = 3'b100,
        IAT_CLK_DIV16 = 3'b101,
        IAT_CLK_DIV4 = 3'b110,
        IAT_CLK_EVENT = 3'b111
    } iat_clk_sel_t;

    typedef enum logic [2:0] {
        IAT_PWR_ACTIVE = 3'b000,
        IAT_PWR_SLEEP = 3'b001,
        IAT_PWR_WATCH = 3'b010,
        IAT_PWR_SUBACTIVE = 3'b011,
        IAT_PWR_SUBSLEEP = 3'b100,
        IAT_PWR_STANDBY = 3'b101
    } iat_power_t;

    typedef struct packed {
        logic reload_mode_select;
        logic [3:0] reserved;
        iat_clk_sel_t clock_select;
    } iat_mode_t;

endpackage : iat_pkg

// >>> rtl/iat_timer.sv
// Interval and auto-reload 8-bit timer with register port and overflow interrupt
//
// What this block does
// - Mode register resets to 0x78; bits 6..3 always read one, writes ignored.
// - Mode bit 7: zero selects interval, one selects auto-reload; resets zero.
// - Clock select codes 000..110 pick divide 8192..4; 111 picks event pin.
// - Event counting advances on rising or falling pin edge, chosen by edge bit.
// - Counter is written only through the load register, readable any time without disturbing the count.
// - Counter and load register share one address: reads counter, writes load.
// - Count clock at 0xff overflows and sets the overflow request flag.
// - Interrupt is requested only while the overflow interrupt enable is one.
// - Interval mode wraps to 0x00 on overflow and keeps counting up.
// - Writing the load register also copies the value into the counter.
// - Auto-reload mode loads the counter from the load register on overflow.
// - Reset clears counter and load register and selects interval mode.
// - Counter runs in active and sleep, halts in every other low-power state.
// - Mode register written in active state, retained in all other states.
// - Clock select 111 makes the counter count edges of the event pin.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module iat_timer
    import iat_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire iat_power_t power_mode_i,
    input wire logic event_input_pin_i,
    output logic overflow_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    iat_mode_t timer_mode_control;
    logic [7:0] timer_count_value;
    logic [7:0] timer_reload_value;
    logic overflow_request_flag;
    logic overflow_interrupt_enable;
    logic event_edge_select;
    logic [IAT_PRESC_WIDTH-1:0] presc;
    logic event_sync1;
    logic event_sync2;
    logic event_last;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic run;
    logic is_active;
    logic wr_mode;
    logic wr_reload;
    logic wr_status;
    logic wr_mask;
    logic wr_edge;
    logic presc_tick;
    logic event_edge;
    logic count_en;
    logic ovf_evt;
    logic [12:0] tick_mask;

    assign is_active = (power_mode_i == IAT_PWR_ACTIVE);
    assign run = is_active || (power_mode_i == IAT_PWR_SLEEP);
    assign wr_mode = reg_write_i && (reg_addr_i == IAT_ADDR_MODE) && is_active;
    assign wr_reload = reg_write_i && (reg_addr_i == IAT_ADDR_COUNT);
    assign wr_status = reg_write_i && (reg_addr_i == IAT_ADDR_STATUS);
    assign wr_mask = reg_write_i && (reg_addr_i == IAT_ADDR_MASK);
    assign wr_edge = reg_write_i && (reg_addr_i == IAT_ADDR_EDGE);

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_mode_control <= iat_mode_t'(IAT_MODE_RESET);
        end else if (wr_mode) begin
            timer_mode_control.reload_mode_select <= reg_wdata_i[IAT_MODE_RELOAD_BIT];
            timer_mode_control.reserved <= IAT_MODE_FIXED_ONES;
            timer_mode_control.clock_select <= iat_clk_sel_t'(reg_wdata_i[2:0]);
        end
    end

    // ------------------------------------------------------------
    // Own control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overflow_interrupt_enable <= 1'b0;
        end else if (wr_mask) begin
            overflow_interrupt_enable <= reg_wdata_i[IAT_MASK_OVF_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_edge_select <= 1'b0;
        end else if (wr_edge) begin
            event_edge_select <= reg_wdata_i[IAT_EDGE_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            presc <= '0;
        end else if (run) begin
            presc <= presc + 13'h0001;
        end
    end

    always_comb begin
        case (timer_mode_control.clock_select)
            IAT_CLK_DIV8192: tick_mask = IAT_MASK_DIV8192;
            IAT_CLK_DIV2048: tick_mask = IAT_MASK_DIV2048;
            IAT_CLK_DIV512: tick_mask = IAT_MASK_DIV512;
            IAT_CLK_DIV256: tick_mask = IAT_MASK_DIV256;
            IAT_CLK_DIV64: tick_mask = IAT_MASK_DIV64;
            IAT_CLK_DIV16: tick_mask = IAT_MASK_DIV16;
            IAT_CLK_DIV4: tick_mask = IAT_MASK_DIV4;
            default: tick_mask = IAT_MASK_DIV8192;
        endcase
    end

    assign presc_tick = ((presc & tick_mask) == tick_mask);

    // ------------------------------------------------------------
    // Event pin synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_sync1 <= 1'b0;
            event_sync2 <= 1'b0;
            event_last <= 1'b0;
        end else begin
            event_sync1 <= event_input_pin_i;
            event_sync2 <= event_sync1;
            event_last <= event_sync2;
        end
    end

    // One rising edge selects rising, zero selects falling
    assign event_edge = event_edge_select ? (event_sync2 && !event_last)
                                          : (!event_sync2 && event_last);

    assign count_en = run && ((timer_mode_control.clock_select == IAT_CLK_EVENT) ? event_edge
                                                                                : presc_tick);
    assign ovf_evt = count_en && !wr_reload && (timer_count_value == IAT_COUNT_MAX);

    // ------------------------------------------------------------
    // Load register and counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_reload_value <= IAT_RELOAD_RESET;
        end else if (wr_reload) begin
            timer_reload_value <= reg_wdata_i;
        end
    end

    // A software load wins over a count clock in the same cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_count_value <= IAT_COUNT_RESET;
        end else if (wr_reload) begin
            timer_count_value <= reg_wdata_i;
        end else if (ovf_evt) begin
            if (timer_mode_control.reload_mode_select) begin
                timer_count_value <= timer_reload_value;
            end else begin
                timer_count_value <= IAT_COUNT_WRAP;
            end
        end else if (count_en) begin
            timer_count_value <= timer_count_value + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overflow_request_flag <= 1'b0;
        end else if (ovf_evt) begin
            overflow_request_flag <= 1'b1;
        end else if (wr_status && reg_wdata_i[IAT_STATUS_OVF_BIT]) begin
            overflow_request_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= ovf_evt;
        end
    end

    assign irq_o = overflow_request_flag && overflow_interrupt_enable;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                IAT_ADDR_MODE: reg_rdata_o <= timer_mode_control;
                IAT_ADDR_COUNT: reg_rdata_o <= timer_count_value;
                IAT_ADDR_STATUS: reg_rdata_o <= {7'h00, overflow_request_flag};
                IAT_ADDR_MASK: reg_rdata_o <= {7'h00, overflow_interrupt_enable};
                IAT_ADDR_EDGE: reg_rdata_o <= {7'h00, event_edge_select};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_reserved;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (reg_read_i && reg_addr_i == IAT_ADDR_MODE) |=> (reg_rdata_o[6:3] == 4'hf);
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("Mode reserved bits not one");

    property p_mode_select;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_mode) |=> (timer_mode_control.reload_mode_select == $past(reg_wdata_i[7]));
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("Mode bit 7 not stored");

    property p_div4_tick;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (run && timer_mode_control.clock_select == IAT_CLK_DIV4 && presc_tick)
            |-> (presc[1:0] == 2'b11);
    endproperty
    a_div4_tick: assert property (p_div4_tick) else $error("Divide by four tick misplaced");

    property p_event_count;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (run && timer_mode_control.clock_select == IAT_CLK_EVENT && event_edge && !wr_reload
            && timer_count_value != 8'hff) |=> (timer_count_value == $past(timer_count_value) + 8'h01);
    endproperty
    a_event_count: assert property (p_event_count) else $error("Event edge not counted");

    property p_event_pulse;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        event_edge |=> !event_edge;
    endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("Event pulse longer than a cycle");

    property p_count_read;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (reg_read_i && reg_addr_i == IAT_ADDR_COUNT) |=> (reg_rdata_o == $past(timer_count_value));
    endproperty
    a_count_read: assert property (p_count_read) else $error("Counter read wrong");

    property p_shared_write;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_reload |=> (timer_reload_value == $past(reg_wdata_i)) && (timer_count_value == $past(reg_wdata_i));
    endproperty
    a_shared_write: assert property (p_shared_write) else $error("Load write not copied");

    property p_flag_set;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ovf_evt |=> overflow_request_flag && overflow_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Overflow flag not set");

    property p_irq_gate;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        irq_o |-> (overflow_interrupt_enable && overflow_request_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt while masked");

    property p_interval_wrap;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (ovf_evt && !timer_mode_control.reload_mode_select) |=> (timer_count_value == 8'h00);
    endproperty
    a_interval_wrap: assert property (p_interval_wrap) else $error("Interval wrap not zero");

    property p_auto_reload;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (ovf_evt && timer_mode_control.reload_mode_select) |=> (timer_count_value == $past(timer_reload_value));
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("Reload value not loaded");

    property p_halt;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!run && !wr_reload) |=> $stable(timer_count_value);
    endproperty
    a_halt: assert property (p_halt) else $error("Counter moved while halted");

    property p_mode_retain;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!is_active) |=> $stable(timer_mode_control);
    endproperty
    a_mode_retain: assert property (p_mode_retain) else $error("Mode changed outside active");

    property p_count_step;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (count_en && !wr_reload && timer_count_value != IAT_COUNT_MAX) |=> (timer_count_value == $past(timer_count_value) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("Counter did not step up");

    property p_count_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (run && !count_en && !wr_reload) |=> $stable(timer_count_value);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("Counter moved without count clock");

    property p_ovf_pulse;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        overflow_o |=> !overflow_o;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("Overflow pulse longer than a cycle");

    property p_mode_refused;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (reg_write_i && reg_addr_i == IAT_ADDR_MODE && !is_active) |=> $stable(timer_mode_control);
    endproperty
    a_mode_refused: assert property (p_mode_refused) else $error("Mode write taken outside active");

    property p_presc_halt;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!run) |=> $stable(presc);
    endproperty
    a_presc_halt: assert property (p_presc_halt) else $error("Prescaler moved while halted");

endmodule : iat_timer

`default_nettype wire

// >>> tb/iat_event_source.sv
// External event source model driving the event pin
`timescale 1ns/1ps
`default_nettype none

module iat_event_source (
    input wire logic sys_clk_i,
    output logic event_pin_o
);
    initial begin
        event_pin_o = 1'b0;
    end

    // Level change after a clock edge, then held a number of cycles
    task automatic set_level(input logic level, input int hold);
        @(posedge sys_clk_i);
        event_pin_o <= level;
        repeat (hold) @(posedge sys_clk_i);
    endtask : set_level
endmodule : iat_event_source

`default_nettype wire

// >>> tb/iat_timer_tb_top.sv
// Self-checking testbench of the interval and auto-reload timer
`timescale 1ns/1ps
`default_nettype none

module iat_timer_tb_top
    import iat_pkg::*;
;
    logic sys_clk_i;
    logic reset_n_i;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    iat_power_t pwr;
    logic pin;
    logic ovf;
    logic irq;
    int err_total;
    int check_count;
    logic [7:0] d;
    logic [7:0] a;
    int per;
    int divs[7] = '{8192, 2048, 512, 256, 64, 16, 4};

    iat_timer dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
        .reg_rdata_o(rdata), .power_mode_i(pwr), .event_input_pin_i(pin),
        .overflow_o(ovf), .irq_o(irq)
    );

    iat_event_source ev (.sys_clk_i(sys_clk_i), .event_pin_o(pin));

    // ------------------------------------------------------------
    // Clock, bus tasks and compare
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [15:0] ad, input logic [7:0] v);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= ad;
        wdata <= v;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] ad, output logic [7:0] v);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= ad;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic wait_ovf(output int cyc);
        cyc = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            cyc++;
        end while (ovf !== 1'b1 && cyc < 20000);
        check(32'(cyc < 20000), 32'h1);
    endtask : wait_ovf

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge sys_clk_i);
        err_total++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        check_count = 0;
        reset_n_i = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        pwr = IAT_PWR_ACTIVE;
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd_reg(IAT_ADDR_MODE, d);
        check(d, 8'h78);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h00);
        rd_reg(IAT_ADDR_STATUS, d);
        check(d, 8'h00);
        rd_reg(16'hff00, d);
        check(d, 8'h00);
        wr_reg(IAT_ADDR_MODE, 8'h86);
        rd_reg(IAT_ADDR_MODE, d);
        check(d, 8'hfe);
        $display("test reset and mode done");

        for (int i = 0; i < 7; i++) begin
            wr_reg(IAT_ADDR_MODE, 8'h80 | 8'(i));
            wr_reg(IAT_ADDR_COUNT, 8'hff);
            wait_ovf(per);
            wait_ovf(per);
            check(per, divs[i]);
        end
        wr_reg(IAT_ADDR_MODE, 8'h86);
        wr_reg(IAT_ADDR_COUNT, 8'hf0);
        wait_ovf(per);
        wait_ovf(per);
        check(per, 64);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'hf0);
        wr_reg(IAT_ADDR_MODE, 8'h06);
        wait_ovf(per);
        wait_ovf(per);
        check(per, 1024);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h00);
        $display("test clock select and reload done");

        for (int p = 2; p < 6; p++) begin
            @(posedge sys_clk_i);
            pwr <= iat_power_t'(3'(p));
            rd_reg(IAT_ADDR_COUNT, a);
            wr_reg(IAT_ADDR_MODE, 8'h05);
            repeat (40) @(posedge sys_clk_i);
            rd_reg(IAT_ADDR_COUNT, d);
            check(d, a);
        end
        @(posedge sys_clk_i);
        pwr <= IAT_PWR_SLEEP;
        rd_reg(IAT_ADDR_COUNT, a);
        repeat (40) @(posedge sys_clk_i);
        rd_reg(IAT_ADDR_COUNT, d);
        check(32'(d !== a), 32'h1);
        @(posedge sys_clk_i);
        pwr <= IAT_PWR_ACTIVE;
        rd_reg(IAT_ADDR_MODE, d);
        check(d, 8'h7e);
        $display("test power states done");

        wr_reg(IAT_ADDR_MODE, 8'h07);
        wr_reg(IAT_ADDR_COUNT, 8'hfe);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'hfe);
        rd_reg(IAT_ADDR_MODE, d);
        check(d, 8'h7f);
        ev.set_level(1'b1, 6);
        ev.set_level(1'b0, 6);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'hff);
        ev.set_level(1'b1, 6);
        ev.set_level(1'b0, 6);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h00);
        rd_reg(IAT_ADDR_STATUS, d);
        check(d, 8'h01);
        check(irq, 1'b0);
        wr_reg(IAT_ADDR_MASK, 8'h01);
        #1;
        check(irq, 1'b1);
        wr_reg(IAT_ADDR_STATUS, 8'h01);
        #1;
        check(irq, 1'b0);
        wr_reg(IAT_ADDR_EDGE, 8'h01);
        wr_reg(IAT_ADDR_COUNT, 8'h10);
        ev.set_level(1'b1, 6);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h11);
        ev.set_level(1'b0, 6);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h11);
        wr_reg(IAT_ADDR_MODE, 8'h87);
        wr_reg(IAT_ADDR_COUNT, 8'hff);
        wr_reg(IAT_ADDR_COUNT, 8'h80);
        ev.set_level(1'b1, 2);
        ev.set_level(1'b0, 1);
        ev.set_level(1'b1, 6);
        rd_reg(IAT_ADDR_COUNT, d);
        check(d, 8'h82);
        $display("test event counting and interrupt done");
        finish_test();
    end
endmodule : iat_timer_tb_top

`default_nettype wire
